// ---- rtl/urs_pkg.sv ----
// ============================================================
// shared constants for the receive status and baud block
package urs_pkg;

  // ============================================================
  // register byte offsets
  localparam logic [11:0] URS_OFS_STATUS_A  = 12'h000;
  localparam logic [11:0] URS_OFS_CONTROL_B = 12'h004;
  localparam logic [11:0] URS_OFS_CONTROL_C = 12'h008;
  localparam logic [11:0] URS_OFS_DIV_LOW   = 12'h00C;
  localparam logic [11:0] URS_OFS_DIV_HIGH  = 12'h010;
  localparam logic [11:0] URS_OFS_DATA      = 12'h014;

  // ============================================================
  // field positions
  localparam int URS_STA_RXC   = 7;
  localparam int URS_STA_FE    = 4;
  localparam int URS_STA_DOR   = 3;
  localparam int URS_STA_PE    = 2;
  localparam int URS_STA_U2X   = 1;
  localparam int URS_CTB_RXCIE = 7;
  localparam int URS_CTB_RXEN  = 4;
  localparam int URS_CTC_MSEL  = 6;
  localparam int URS_CTC_UPM1  = 5;
  localparam int URS_CTC_UPM0  = 4;
  localparam int URS_CTC_USBS  = 3;
  localparam int URS_CTC_XDIR  = 0;
  localparam int URS_ENT_FE    = 10;
  localparam int URS_ENT_DOR   = 9;
  localparam int URS_ENT_PE    = 8;

  // ============================================================
  // widths and values after reset
  localparam int                 URS_DIV_W   = 12;
  localparam int                 URS_ENT_W   = 11;
  localparam logic [7:0]         URS_STA_RST = 8'h00;
  localparam logic [7:0]         URS_CTB_RST = 8'h00;
  localparam logic [7:0]         URS_CTC_RST = 8'h00;
  localparam logic [URS_DIV_W-1:0] URS_DIV_RST = 12'h000;

  // ============================================================
  // last phase index of the 16, 8 and 2 state recovery modes
  localparam logic [3:0] URS_PH_LAST_NORM   = 4'hF;
  localparam logic [3:0] URS_PH_LAST_DOUBLE = 4'h7;
  localparam logic [3:0] URS_PH_LAST_SYNC   = 4'h1;
  localparam logic [2:0] URS_BIT_LAST       = 3'h7;

  typedef enum logic [2:0] {
    URS_IDLE,
    URS_START,
    URS_DATA,
    URS_PARITY,
    URS_STOP
  } urs_rx_state_e;

endpackage

// ---- rtl/urs_baud_gen.sv ----
`timescale 1ns/10ps
module urs_baud_gen
  import urs_pkg::*;
(
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // divisor control
  input  wire logic [URS_DIV_W-1:0] divisor,
  input  wire logic                 reload,
  // baud clock pulse
  output logic                      tick
);

  logic [URS_DIV_W-1:0] cnt_reg;

  // ============================================================
  // down-counter
  // reload at zero or write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= URS_DIV_RST;
    end else if (reload || cnt_reg == '0) begin
      cnt_reg <= divisor;
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign tick = (cnt_reg == '0) && !reload;

  // ============================================================
  // checks
  reload_value_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (reload || cnt_reg == '0) |=> cnt_reg == $past(divisor))
    else $error("baud counter did not reload the divisor");

  tick_at_zero_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (cnt_reg == 12'h001 && !reload) ##1 !reload |-> tick)
    else $error("baud pulse missing when counter reached zero");

endmodule

// ---- rtl/urs_rx_status.sv ----
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/10ps
module urs_rx_status
  import urs_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line and clock pin
  input  wire logic        rxd,
  input  wire logic        xck_in,
  output logic             xck_out,
  output logic             xck_oe,
  output logic             tx_tick,
  // interrupt
  input  wire logic        global_irq_enable,
  output logic             rx_complete_irq
);

  logic                 double_speed_reg;
  logic                 receive_complete_irq_enable_reg;
  logic                 receiver_enable_reg;
  logic                 usart_mode_select_reg;
  logic                 parity_mode_high_reg;
  logic                 parity_mode_low_reg;
  logic                 stop_bit_count_select_reg;
  logic                 sync_clock_pin_direction_reg;
  logic [URS_DIV_W-1:0] baud_divisor_reg;
  logic [31:0]          prdata_reg;
  logic                 wr_acc;
  logic                 rd_acc;
  logic                 addr_ok;
  logic                 div_low_wr;
  logic                 baud_tick;
  logic                 sync_master;
  logic                 sync_slave;
  logic [3:0]           ph_last;
  logic [3:0]           tx_cnt_reg;
  logic                 tx_tick_reg;
  logic                 xck_in_reg;
  logic                 xck_out_reg;
  logic                 xck_rise;
  logic                 xck_fall;
  logic                 sample_evt;
  logic                 start_det;
  logic                 frame_done;
  urs_rx_state_e        state_reg;
  logic [3:0]           ph_reg;
  logic [2:0]           bit_reg;
  logic [7:0]           shift_reg;
  logic                 par_bit_reg;
  logic                 pe_calc;
  logic [URS_ENT_W-1:0] frame_entry;
  logic [URS_ENT_W-1:0] hold_reg;
  logic                 hold_valid_reg;
  logic                 ovr_pend_reg;
  logic [URS_ENT_W-1:0] fifo_mem [2];
  logic                 wr_ptr_reg;
  logic                 rd_ptr_reg;
  logic [1:0]           fill_reg;
  logic                 pop;
  logic                 push;
  logic                 space;
  logic [URS_ENT_W-1:0] push_entry;
  logic [URS_ENT_W-1:0] head;
  logic                 rxc;
  logic                 status_fe;
  logic                 status_dor;
  logic                 status_pe;
  logic [7:0]           rd_byte;

  // ============================================================
  // apb decode, zero wait states
  assign wr_acc     = psel && penable && pwrite;
  assign rd_acc     = psel && penable && !pwrite;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !addr_ok;
  assign prdata     = prdata_reg;
  assign div_low_wr = wr_acc && paddr == URS_OFS_DIV_LOW;

  always_comb begin
    case (paddr)
      URS_OFS_STATUS_A, URS_OFS_CONTROL_B, URS_OFS_CONTROL_C,
      URS_OFS_DIV_LOW, URS_OFS_DIV_HIGH, URS_OFS_DATA: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // ============================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      double_speed_reg                <= URS_STA_RST[URS_STA_U2X];
      receive_complete_irq_enable_reg <= URS_CTB_RST[URS_CTB_RXCIE];
      receiver_enable_reg             <= URS_CTB_RST[URS_CTB_RXEN];
      usart_mode_select_reg           <= URS_CTC_RST[URS_CTC_MSEL];
      parity_mode_high_reg            <= URS_CTC_RST[URS_CTC_UPM1];
      parity_mode_low_reg             <= URS_CTC_RST[URS_CTC_UPM0];
      stop_bit_count_select_reg       <= URS_CTC_RST[URS_CTC_USBS];
      sync_clock_pin_direction_reg    <= URS_CTC_RST[URS_CTC_XDIR];
      baud_divisor_reg                <= URS_DIV_RST;
    end else if (wr_acc) begin
      case (paddr)
        URS_OFS_STATUS_A: begin
          double_speed_reg <= pwdata[URS_STA_U2X];
        end
        URS_OFS_CONTROL_B: begin
          receive_complete_irq_enable_reg <= pwdata[URS_CTB_RXCIE];
          receiver_enable_reg             <= pwdata[URS_CTB_RXEN];
        end
        URS_OFS_CONTROL_C: begin
          usart_mode_select_reg        <= pwdata[URS_CTC_MSEL];
          parity_mode_high_reg         <= pwdata[URS_CTC_UPM1];
          parity_mode_low_reg          <= pwdata[URS_CTC_UPM0];
          stop_bit_count_select_reg    <= pwdata[URS_CTC_USBS];
          sync_clock_pin_direction_reg <= pwdata[URS_CTC_XDIR];
        end
        URS_OFS_DIV_LOW: begin
          baud_divisor_reg[7:0] <= pwdata[7:0];
        end
        URS_OFS_DIV_HIGH: begin
          baud_divisor_reg[URS_DIV_W-1:8] <= pwdata[URS_DIV_W-9:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ============================================================
  // baud generator and clock selection
  urs_baud_gen u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .divisor (baud_divisor_reg),
    .reload  (div_low_wr),
    .tick    (baud_tick)
  );

  assign sync_master = usart_mode_select_reg && sync_clock_pin_direction_reg;
  assign sync_slave  = usart_mode_select_reg && !sync_clock_pin_direction_reg;

  always_comb begin
    if (usart_mode_select_reg) begin
      ph_last = URS_PH_LAST_SYNC;
    end else if (double_speed_reg) begin
      ph_last = URS_PH_LAST_DOUBLE;
    end else begin
      ph_last = URS_PH_LAST_NORM;
    end
  end

  // pin inputs are synchronous, so one stage is enough for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xck_in_reg  <= 1'b0;
      xck_out_reg <= 1'b0;
    end else begin
      xck_in_reg <= xck_in;
      if (!sync_master) begin
        xck_out_reg <= 1'b0;
      end else if (baud_tick) begin
        xck_out_reg <= !xck_out_reg;
      end
    end
  end

  assign xck_rise = xck_in && !xck_in_reg;
  assign xck_fall = !xck_in && xck_in_reg;
  assign xck_out  = xck_out_reg;
  assign xck_oe   = sync_master;

  // slave samples on the pin edge
  always_comb begin
    if (sync_slave) begin
      sample_evt = xck_rise;
    end else if (sync_master) begin
      sample_evt = baud_tick && !xck_out_reg;
    end else begin
      sample_evt = baud_tick && ph_reg == ph_last
                   && state_reg != URS_START;
    end
  end

  // ============================================================
  // transmitter clock divider
  // divide baud pulse per mode; sync slave follows the pin falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_reg  <= 4'h0;
      tx_tick_reg <= 1'b0;
    end else if (sync_slave) begin
      tx_cnt_reg  <= 4'h0;
      tx_tick_reg <= xck_fall;
    end else begin
      tx_tick_reg <= baud_tick && tx_cnt_reg >= ph_last;
      if (baud_tick) begin
        tx_cnt_reg <= (tx_cnt_reg >= ph_last) ? 4'h0 : tx_cnt_reg + 4'h1;
      end
    end
  end

  assign tx_tick = tx_tick_reg;

  // ============================================================
  // receive frame sequencer, eight data bits, lsb first
  assign start_det = receiver_enable_reg && state_reg == URS_IDLE && !rxd
                     && (usart_mode_select_reg ? sample_evt : baud_tick);
  assign frame_done = receiver_enable_reg && state_reg == URS_STOP && sample_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= URS_IDLE;
      ph_reg      <= 4'h0;
      bit_reg     <= 3'h0;
      shift_reg   <= 8'h00;
      par_bit_reg <= 1'b0;
    end else if (!receiver_enable_reg) begin
      state_reg <= URS_IDLE;
      ph_reg    <= 4'h0;
    end else begin
      if (baud_tick && state_reg != URS_IDLE) begin
        ph_reg <= (ph_reg >= ph_last) ? 4'h0 : ph_reg + 4'h1;
      end
      case (state_reg)
        URS_IDLE: begin
          ph_reg  <= 4'h0;
          bit_reg <= 3'h0;
          if (start_det) begin
            state_reg <= usart_mode_select_reg ? URS_DATA : URS_START;
          end
        end
        URS_START: begin
          // start bit must still be low half a bit later
          if (baud_tick && ph_reg == (ph_last >> 1)) begin
            ph_reg    <= 4'h0;
            state_reg <= rxd ? URS_IDLE : URS_DATA;
          end
        end
        URS_DATA: begin
          if (sample_evt) begin
            shift_reg <= {rxd, shift_reg[7:1]};
            bit_reg   <= bit_reg + 3'h1;
            if (bit_reg == URS_BIT_LAST) begin
              state_reg <= parity_mode_high_reg ? URS_PARITY : URS_STOP;
            end
          end
        end
        URS_PARITY: begin
          if (sample_evt) begin
            par_bit_reg <= rxd;
            state_reg   <= URS_STOP;
          end
        end
        // later stop bits fall in idle
        URS_STOP: begin
          if (sample_evt) begin
            state_reg <= URS_IDLE;
          end
        end
        default: begin
          state_reg <= URS_IDLE;
        end
      endcase
    end
  end

  // low bit zero even, one odd
  assign pe_calc = parity_mode_high_reg
                   && (^shift_reg ^ par_bit_reg ^ parity_mode_low_reg);

  // stop bit sampled low is an error
  assign frame_entry = {!rxd, 1'b0, pe_calc, shift_reg};

  // ============================================================
  // two-entry receive buffer with shift holding stage
  assign pop   = rd_acc && paddr == URS_OFS_DATA && rxc;
  assign space = (fill_reg != 2'd2) || pop;
  assign push  = receiver_enable_reg && space && (hold_valid_reg || frame_done);

  always_comb begin
    push_entry              = hold_valid_reg ? hold_reg : frame_entry;
    push_entry[URS_ENT_DOR] = ovr_pend_reg;
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      fifo_mem[wr_ptr_reg] <= push_entry;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      fill_reg   <= 2'd0;
    end else if (!receiver_enable_reg) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      fill_reg   <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      case ({push, pop})
        2'b10:   fill_reg <= fill_reg + 2'd1;
        2'b01:   fill_reg <= fill_reg - 2'd1;
        default: fill_reg <= fill_reg;
      endcase
    end
  end

  // a frame finishing into a full buffer waits here; a later one overwrites it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg       <= '0;
      hold_valid_reg <= 1'b0;
      ovr_pend_reg   <= 1'b0;
    end else if (!receiver_enable_reg) begin
      hold_valid_reg <= 1'b0;
      ovr_pend_reg   <= 1'b0;
    end else begin
      if (frame_done && (hold_valid_reg || !space)) begin
        hold_reg       <= frame_entry;
        hold_valid_reg <= 1'b1;
      end else if (push) begin
        hold_valid_reg <= 1'b0;
      end
      if (start_det && hold_valid_reg && fill_reg == 2'd2) begin
        ovr_pend_reg <= 1'b1;
      end else if (push) begin
        ovr_pend_reg <= 1'b0;
      end
    end
  end

  // ============================================================
  // status view and read data
  // head moves with the pop edge
  assign head = fifo_mem[rd_ptr_reg];
  assign rxc        = fill_reg != 2'd0;
  assign status_fe  = rxc && head[URS_ENT_FE];
  assign status_dor = rxc && head[URS_ENT_DOR];
  assign status_pe  = rxc && parity_mode_high_reg && head[URS_ENT_PE];

  always_comb begin
    rd_byte = 8'h00;
    case (paddr)
      URS_OFS_STATUS_A: begin
        rd_byte[URS_STA_RXC] = rxc;
        rd_byte[URS_STA_FE]  = status_fe;
        rd_byte[URS_STA_DOR] = status_dor;
        rd_byte[URS_STA_PE]  = status_pe;
        rd_byte[URS_STA_U2X] = double_speed_reg;
      end
      URS_OFS_CONTROL_B: begin
        rd_byte[URS_CTB_RXCIE] = receive_complete_irq_enable_reg;
        rd_byte[URS_CTB_RXEN]  = receiver_enable_reg;
      end
      URS_OFS_CONTROL_C: begin
        rd_byte[URS_CTC_MSEL] = usart_mode_select_reg;
        rd_byte[URS_CTC_UPM1] = parity_mode_high_reg;
        rd_byte[URS_CTC_UPM0] = parity_mode_low_reg;
        rd_byte[URS_CTC_USBS] = stop_bit_count_select_reg;
        rd_byte[URS_CTC_XDIR] = sync_clock_pin_direction_reg;
      end
      URS_OFS_DIV_LOW:  rd_byte = baud_divisor_reg[7:0];
      URS_OFS_DIV_HIGH: rd_byte = {4'h0, baud_divisor_reg[URS_DIV_W-1:8]};
      URS_OFS_DATA:     rd_byte = rxc ? head[7:0] : 8'h00;
      default:          rd_byte = 8'h00;
    endcase
  end

  // read data is caught in the setup cycle so the access phase sees a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  assign rx_complete_irq = rxc && receive_complete_irq_enable_reg
                           && global_irq_enable;

  // ============================================================
  // checks
  flush_clears_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    !receiver_enable_reg |=> !rxc && !rx_complete_irq)
    else $error("receiver disable did not flush the buffer");

  irq_follows_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (pop && fill_reg == 2'd1 && !push) |=> !rx_complete_irq)
    else $error("interrupt stayed up after last character read");

  pop_advance_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (pop && !push && receiver_enable_reg) |=> fill_reg == $past(fill_reg) - 2'd1)
    else $error("data read did not consume a character");

  err_wr_ignored_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == URS_OFS_STATUS_A && !push && !pop && receiver_enable_reg)
    |=> $stable({status_fe, status_dor, status_pe}))
    else $error("status write changed an error flag");

  empty_no_irq_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (fill_reg == 2'd0) |-> !rx_complete_irq && !status_fe && !status_dor)
    else $error("flag or interrupt raised with empty buffer");

  stop_bit_fe_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (frame_done && push && !hold_valid_reg && fill_reg == 2'd0 && !pop)
    ##1 receiver_enable_reg |-> status_fe == !$past(rxd))
    else $error("frame error does not match the stop bit");

  overrun_set_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (start_det && hold_valid_reg && fill_reg == 2'd2) ##1 receiver_enable_reg
    |-> ovr_pend_reg)
    else $error("overrun not recorded on start with full buffer");

  parity_off_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    !parity_mode_high_reg |-> !status_pe)
    else $error("parity error visible with checking disabled");

endmodule

// ---- verif/urs_ser_tx.sv ----
`timescale 1ns/10ps
// ============================================================
// remote serial transmitter: idle high, lsb first
module urs_ser_tx (
  // clock
  pclk,
  // serial line
  rxd
);
  input  wire logic pclk;
  output logic      rxd;

  initial rxd = 1'b1;

  task automatic send(input logic [7:0] d, input logic pen, input logic par,
                      input logic stp, input int bitc);
    logic [10:0] bits;
    int          n;
    bits = pen ? {stp, par, d, 1'b0} : {1'b1, stp, d, 1'b0};
    n = pen ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk) rxd <= bits[i];
      repeat (bitc - 1) @(posedge pclk);
    end
    // one idle bit, so a zero stop bit is never taken for a start
    @(posedge pclk) rxd <= 1'b1;
    repeat (bitc) @(posedge pclk);
  endtask
endmodule

// ---- verif/tb_usart_rx_status_baud_gen.sv ----
`timescale 1ns/10ps
module tb_usart_rx_status_baud_gen
  import urs_pkg::*;
();
  // ============================================================
  // stimulus and observed signals
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        gie = 1'b0, xck_in = 1'b0, perr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, rxd, xck_out, xck_oe, tx_tick, irq;
  int          err_count = 0, checks = 0, seed = 32'hfe59;
  int          q[$], hold = 0, hold_v = 0, ovr = 0, ie = 0, ds = 0, bitc = 16, sclk = 0;

  always #5 pclk = ~pclk;

  urs_rx_status DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .xck_in(xck_in), .xck_out(xck_out), .xck_oe(xck_oe),
    .tx_tick(tx_tick), .global_irq_enable(gie), .rx_complete_irq(irq));
  urs_ser_tx u_tx (.pclk(pclk), .rxd(rxd));

  // ============================================================
  // shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    cmp(n < 20, 1'b1, "bus answer");
    if (n >= 20) close_out();
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // the first gap may straddle a mode or divisor change, so the third is measured
  task automatic tick_gap(input int exp);
    int n;
    n = 0;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (tx_tick !== 1'b1 && n < 200);
    end
    cmp(n, exp, "tick gap");
    if (n >= 200) close_out();
  endtask

  // buffer model: two entries plus one waiting frame
  task automatic push(input int e);
    if (q.size() < 2) begin
      q.push_back(e);
    end else begin
      if (hold_v) ovr = 1;
      hold = e;
      hold_v = 1;
    end
  endtask

  task automatic frame(input int upm, input int bad, input logic stp);
    logic [7:0] d;
    logic       par;
    d = 8'($random(seed));
    // even parity when low mode bit is zero
    par = ^d ^ upm[0] ^ bad[0];
    // in synchronous slave mode the bench clocks the pin mid-bit, idle low
    fork
      u_tx.send(d, upm[1], par, stp, bitc);
      for (int i = 0; i < 10 + upm[1] && sclk != 0; i++) begin
        repeat (bitc / 2) @(posedge pclk);
        xck_in <= 1'b1;
        repeat (bitc / 2) @(posedge pclk);
        xck_in <= 1'b0;
      end
    join
    // entry carries stop and parity results
    push({~stp, 1'b0, upm[1] & bad[0], d});
  endtask

  task automatic rd_check();
    int e;
    int r;
    e = (q.size() > 0) ? q[0] : 0;
    r = $random(seed);
    gie <= r[0];
    apb(1'b0, URS_OFS_STATUS_A, 32'h0000_0000);
    cmp(rd, {(q.size() > 0), 2'b00, e[10:8], ds[0], 1'b0}, "status");
    cmp(irq, (q.size() > 0) && ie != 0 && gie, "irq");
    apb(1'b0, URS_OFS_DATA, 32'h0000_0000);
    cmp(rd, e[7:0], "data");
    if (q.size() > 0) void'(q.pop_front());
    if (hold_v) begin
      q.push_back(hold | (ovr << URS_ENT_DOR));
      hold_v = 0;
      ovr = 0;
    end
  endtask

  // ============================================================
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_check();
    apb(1'b0, 12'h018, 32'h0000_0000);
    cmp(perr, 1'b1, "unmapped");
    apb(1'b1, URS_OFS_DIV_LOW, 32'h0000_0001);
    bitc = 32;
    tick_gap(32);
    apb(1'b1, URS_OFS_CONTROL_B, 32'h0000_0090);
    ie = 1;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, URS_OFS_CONTROL_C, m << 4);
      for (int b = 0; b < 2; b++) begin
        frame(m, b, 1'b1);
        rd_check();
      end
    end
    $display("test parity modes done");
    frame(3, 1, 1'b0);
    frame(3, 0, 1'b1);
    repeat (3) rd_check();
    $display("test stacked flags done");
    repeat (4) frame(3, 0, 1'b1);
    repeat (4) rd_check();
    frame(3, 0, 1'b1);
    rd_check();
    $display("test overrun done");
    frame(3, 0, 1'b1);
    apb(1'b1, URS_OFS_CONTROL_B, 32'h0000_0080);
    q.delete();
    apb(1'b1, URS_OFS_CONTROL_B, 32'h0000_0090);
    rd_check();
    frame(3, 1, 1'b0);
    apb(1'b1, URS_OFS_STATUS_A, 32'h0000_001C);
    rd_check();
    $display("test flush and flag writes done");
    apb(1'b1, URS_OFS_STATUS_A, 32'h0000_0002);
    ds = 1;
    bitc = 16;
    tick_gap(16);
    frame(3, 0, 1'b1);
    rd_check();
    apb(1'b1, URS_OFS_CONTROL_C, 32'h0000_0041);
    @(posedge pclk);
    cmp(xck_oe, 1'b1, "clock pin drive");
    tick_gap(4);
    rd[0] = xck_out;
    repeat (2) @(negedge pclk);
    cmp(xck_out, !rd[0], "clock out toggle");
    apb(1'b1, URS_OFS_CONTROL_C, 32'h0000_0040);
    @(posedge pclk);
    cmp(xck_oe, 1'b0, "clock pin input");
    sclk = 1;
    bitc = 8;
    fork
      frame(0, 0, 1'b1);
      tick_gap(8);
    join
    rd_check();
    $display("test clock modes done");
    close_out();
  end
endmodule
